// [hw/tof_pkg.sv]
// tof_pkg: shared constants and types for the two-wire sensor port.
// assumes both ends compile against it; nothing is imported.
package tof_pkg;

  // ----------------------------------------
  // addressing
  // ----------------------------------------
  localparam logic [7:0] BASE_ADDR = 8'hA8;
  localparam logic DIR_READ = 1'h1;
  localparam logic [3:0] BIT_LAST = 4'h8;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int MCLK_NS = 40;
  localparam int SCL_QTR_NS = 520;
  localparam int SCL_QTR_CYC = (SCL_QTR_NS + MCLK_NS - 1) / MCLK_NS;
  localparam logic [4:0] QTR_LAST = 5'(SCL_QTR_CYC - 1);
  // link clocks during which a start is disregarded after reset
  localparam logic [4:0] PWRUP_CNT = 5'h10;

  // ----------------------------------------
  // states and commands
  // ----------------------------------------
  typedef enum logic [2:0] {
    DS_IDLE = 3'h0,
    DS_ADDR = 3'h1,
    DS_REG = 3'h2,
    DS_WDATA = 3'h3,
    DS_ACKTX = 3'h4,
    DS_RDATA = 3'h5,
    DS_MACK = 3'h6
  } tof_dev_state_t;

  typedef enum logic [2:0] {
    HS_IDLE = 3'h0,
    HS_START = 3'h1,
    HS_ADDR = 3'h2,
    HS_REG = 3'h3,
    HS_WDATA = 3'h4,
    HS_RDATA = 3'h5,
    HS_STOP = 3'h6
  } tof_host_state_t;

  typedef enum logic [1:0] {
    OP_WRITE = 2'h0,
    OP_CURREAD = 2'h1,
    OP_RNDREAD = 2'h2
  } tof_op_t;

  // address byte: fixed upper bits, select pins, direction
  function automatic logic [7:0] tof_addr_byte(input logic [1:0] sel, input logic rd);
    tof_addr_byte = {BASE_ADDR[7:3], sel, rd};
  endfunction : tof_addr_byte

endpackage : tof_pkg

// [hw/tof_i2c_if.sv]
// tof_i2c_if: the two bus wires with both pull-ups resolved here.
// assumes each end drives only through its out/enable pairs.
`timescale 1ns/1ps
interface tof_i2c_if;
  logic scl;
  logic sda;
  logic hostSclOut;
  logic hostSclOe;
  logic hostSdaOut;
  logic hostSdaOe;
  logic devSclOut;
  logic devSclOe;
  logic devSdaOut;
  logic devSdaOe;

  // wired-and with pull-ups
  assign scl = (hostSclOe ? hostSclOut : 1'b1) & (devSclOe ? devSclOut : 1'b1);
  assign sda = (hostSdaOe ? hostSdaOut : 1'b1) & (devSdaOe ? devSdaOut : 1'b1);

  modport dev (
    input scl,
    input sda,
    output devSclOut,
    output devSclOe,
    output devSdaOut,
    output devSdaOe
  );

  modport host (
    input sda,
    output hostSclOut,
    output hostSclOe,
    output hostSdaOut,
    output hostSdaOe
  );
endinterface : tof_i2c_if

// [hw/tof_i2c_dev.sv]
// tof_i2c_dev: slave end of the sensor's two-wire register port.
// assumes a core that answers rdData the cycle after rdStrobe, and
// a link clock fast enough to oversample scl several times per phase.
//
// Functional notes
// [R01] slave only, never drives the clock
// [R02] bytes shifted most significant bit first
// [R03] address 10101 plus two select bits
// [R04] select pins land in address bits 2,1
// [R05] address lsb: 1 read, 0 write
// [R06] sda moves only while scl low
// [R07] data driver released until addressed
// [R08] wait for start; ignore starts during power-up
// [R09] stop returns interface to idle
// [R10] ninth clock: receiver pulls sda low
// [R11] ack matching address and every written byte
// [R12] master acks each read byte wanting more
// [R13] write: address, register, data, stop
// [R14] early stop abandons write, register untouched
// [R15] master ends read with nack, stop
// [R16] random read: write reg, restart, read
// [R17] keep sending while master acks
// [R18] pointer advances after each acked read
// [R19] master stops after last wanted byte
// [R20] pointer kept for later current reads
`timescale 1ns/1ps
module tof_i2c_dev (
  input wire logic mclk, // core clock
  input wire logic resetn, // asynchronous reset, active low
  input wire logic linkClk, // clock of the bus-facing logic
  tof_i2c_if.dev bus, // two-wire bus
  input wire logic addrSelectUpperPin, // address select, bit 2
  input wire logic addrSelectLowerPin, // address select, bit 1
  output logic wrStrobe, // one-cycle register write
  output logic [7:0] wrAddr, // register written
  output logic [7:0] wrData, // byte written
  output logic rdStrobe, // one-cycle register fetch
  output logic [7:0] rdAddr, // register fetched
  input wire logic [7:0] rdData // fetched byte, cycle after rdStrobe
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic sclS1;
    logic sclS2;
    logic sclD;
    logic sdaS1;
    logic sdaS2;
    logic sdaD;
    logic [1:0] selS1;
    logic [1:0] selS2;
    logic [4:0] pwr;
    tof_pkg::tof_dev_state_t st;
    tof_pkg::tof_dev_state_t ackOf;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic isRead;
    logic mAck;
    logic sdaOe;
    logic wrT;
    logic [7:0] wAddr;
    logic [7:0] wData;
    logic rqT;
    logic [7:0] rqAddr;
    logic ackS1;
    logic ackS2;
    logic ackD;
    logic [7:0] rxData;
  } tof_dev_link_t;

  typedef struct packed {
    logic wrS1;
    logic wrS2;
    logic wrD;
    logic rqS1;
    logic rqS2;
    logic rqD;
    logic wrStrobe;
    logic [7:0] wrAddr;
    logic [7:0] wrData;
    logic rdStrobe;
    logic [7:0] rdAddr;
    logic rdPend;
    logic [7:0] rdHold;
    logic rdAckT;
  } tof_dev_core_t;

  tof_dev_link_t link;
  tof_dev_link_t next_link;
  tof_dev_core_t core;
  tof_dev_core_t next_core;

  // ----------------------------------------
  // link domain
  // ----------------------------------------
  always_comb begin
    logic startSeen;
    logic stopSeen;
    logic sclRise;
    logic sclFall;
    logic loadTx;
    next_link = link;
    startSeen = 1'b0;
    stopSeen = 1'b0;
    sclRise = 1'b0;
    sclFall = 1'b0;
    loadTx = 1'b0;
    next_link.sclS1 = bus.scl;
    next_link.sclS2 = link.sclS1;
    next_link.sclD = link.sclS2;
    next_link.sdaS1 = bus.sda;
    next_link.sdaS2 = link.sdaS1;
    next_link.sdaD = link.sdaS2;
    next_link.selS1 = {addrSelectUpperPin, addrSelectLowerPin};
    next_link.selS2 = link.selS1;
    next_link.ackS1 = core.rdAckT;
    next_link.ackS2 = link.ackS1;
    next_link.ackD = link.ackS2;
    // word is stable in the core domain once its toggle arrives
    if (link.ackS2 != link.ackD) begin
      next_link.rxData = core.rdHold;
    end
    if (link.pwr != 5'h00) begin
      next_link.pwr = link.pwr - 5'h01;
    end
    // sda edges with scl high are framing only [R06]
    startSeen = link.sclS2 && link.sclD && link.sdaD && !link.sdaS2;
    stopSeen = link.sclS2 && link.sclD && !link.sdaD && link.sdaS2;
    sclRise = link.sclS2 && !link.sclD;
    sclFall = !link.sclS2 && link.sclD;
    if (stopSeen) begin
      next_link.st = tof_pkg::DS_IDLE; // [R09] [R14]
      next_link.sdaOe = 1'b0;
    end else if (startSeen && link.pwr == 5'h00) begin
      next_link.st = tof_pkg::DS_ADDR; // [R08] [R16]
      next_link.bitCnt = 4'h0;
      next_link.sdaOe = 1'b0;
    end else begin
      case (link.st)
        tof_pkg::DS_ADDR, tof_pkg::DS_REG, tof_pkg::DS_WDATA: begin
          if (sclRise && link.bitCnt != tof_pkg::BIT_LAST) begin
            next_link.shift = {link.shift[6:0], link.sdaS2}; // [R02]
            next_link.bitCnt = link.bitCnt + 4'h1;
          end else if (sclFall && link.bitCnt == tof_pkg::BIT_LAST) begin
            next_link.bitCnt = 4'h0;
            if (link.st != tof_pkg::DS_ADDR
                || {link.shift[7:1], 1'b0} == tof_pkg::tof_addr_byte(link.selS2, 1'b0)) begin
              next_link.sdaOe = 1'b1; // [R03] [R04] [R10] [R11]
              next_link.st = tof_pkg::DS_ACKTX;
              next_link.ackOf = link.st;
              if (link.st == tof_pkg::DS_ADDR) begin
                next_link.isRead = link.shift[0] == tof_pkg::DIR_READ; // [R05]
                if (link.shift[0] == tof_pkg::DIR_READ) begin
                  // fetch early so the byte is home by the ack's end
                  next_link.rqAddr = link.ptr; // [R20]
                  next_link.rqT = !link.rqT;
                end
              end
            end else begin
              next_link.st = tof_pkg::DS_IDLE; // [R07]
            end
          end
        end
        tof_pkg::DS_ACKTX: begin
          if (sclFall) begin
            next_link.sdaOe = 1'b0; // [R10]
            case (link.ackOf)
              tof_pkg::DS_ADDR: begin
                if (link.isRead) begin
                  loadTx = 1'b1;
                end else begin
                  next_link.st = tof_pkg::DS_REG;
                end
              end
              tof_pkg::DS_REG: begin
                next_link.ptr = link.shift; // [R20]
                next_link.st = tof_pkg::DS_WDATA;
              end
              tof_pkg::DS_WDATA: begin
                // only after data and ack are complete [R13] [R14]
                next_link.wAddr = link.ptr;
                next_link.wData = link.shift;
                next_link.wrT = !link.wrT;
                next_link.ptr = link.ptr + 8'h01;
                next_link.st = tof_pkg::DS_WDATA;
              end
              default: begin
                next_link.st = tof_pkg::DS_IDLE;
              end
            endcase
          end
        end
        tof_pkg::DS_RDATA: begin
          if (sclFall) begin
            if (link.bitCnt == tof_pkg::BIT_LAST) begin
              next_link.sdaOe = 1'b0; // [R10]
              next_link.st = tof_pkg::DS_MACK;
            end else begin
              next_link.sdaOe = !link.shift[7]; // [R02] [R06]
              next_link.shift = {link.shift[6:0], 1'b0};
              next_link.bitCnt = link.bitCnt + 4'h1;
            end
          end
        end
        tof_pkg::DS_MACK: begin
          if (sclRise) begin
            next_link.mAck = !link.sdaS2; // [R12]
            if (!link.sdaS2) begin
              next_link.ptr = link.ptr + 8'h01; // [R18]
              next_link.rqAddr = link.ptr + 8'h01;
              next_link.rqT = !link.rqT;
            end
          end else if (sclFall) begin
            if (link.mAck) begin
              loadTx = 1'b1; // [R17]
            end else begin
              next_link.st = tof_pkg::DS_IDLE; // [R15] [R19]
            end
          end
        end
        default: begin
          next_link.sdaOe = 1'b0;
        end
      endcase
    end
    if (loadTx) begin
      next_link.sdaOe = !link.rxData[7]; // [R02]
      next_link.shift = {link.rxData[6:0], 1'b0};
      next_link.bitCnt = 4'h1;
      next_link.st = tof_pkg::DS_RDATA;
    end
  end

  always_ff @(posedge linkClk or negedge resetn) begin
    if (!resetn) begin
      link <= '0; // [R07]
      link.pwr <= tof_pkg::PWRUP_CNT; // [R08]
    end else begin
      link <= next_link;
    end
  end

  // ----------------------------------------
  // core domain
  // ----------------------------------------
  always_comb begin
    next_core = core;
    next_core.wrS1 = link.wrT;
    next_core.wrS2 = core.wrS1;
    next_core.wrD = core.wrS2;
    next_core.rqS1 = link.rqT;
    next_core.rqS2 = core.rqS1;
    next_core.rqD = core.rqS2;
    next_core.wrStrobe = 1'b0;
    next_core.rdStrobe = 1'b0;
    if (core.wrS2 != core.wrD) begin
      next_core.wrStrobe = 1'b1; // [R13]
      next_core.wrAddr = link.wAddr;
      next_core.wrData = link.wData;
    end
    if (core.rqS2 != core.rqD) begin
      next_core.rdStrobe = 1'b1;
      next_core.rdAddr = link.rqAddr;
      next_core.rdPend = 1'b1;
    end else if (core.rdPend && !core.rdStrobe) begin
      next_core.rdHold = rdData;
      next_core.rdAckT = !core.rdAckT;
      next_core.rdPend = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      core <= '0;
    end else begin
      core <= next_core;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign bus.devSclOut = 1'b0;
  assign bus.devSclOe = 1'b0; // [R01]
  assign bus.devSdaOut = 1'b0;
  assign bus.devSdaOe = link.sdaOe;
  assign wrStrobe = core.wrStrobe;
  assign wrAddr = core.wrAddr;
  assign wrData = core.wrData;
  assign rdStrobe = core.rdStrobe;
  assign rdAddr = core.rdAddr;

endmodule : tof_i2c_dev

// [hw/tof_i2c_host.sv]
// tof_i2c_host: bus master end; makes scl from mclk by a divider.
// assumes one command at a time, accepted only while not busy.
`timescale 1ns/1ps
module tof_i2c_host (
  input wire logic mclk, // master clock
  input wire logic resetn, // asynchronous reset, active low
  tof_i2c_if.host bus, // two-wire bus
  input wire logic cmdValid, // start a command when idle
  input wire tof_pkg::tof_op_t cmdOp, // write, current read, random read
  input wire logic [1:0] cmdSel, // target select bits
  input wire logic [7:0] cmdReg, // register address
  input wire logic [7:0] cmdData, // write byte
  input wire logic [7:0] cmdCount, // bytes to read, 0 counts as 1
  output logic busy, // command in progress
  output logic rdValid, // one-cycle read byte strobe
  output logic [7:0] rdByte, // byte read
  output logic done, // one-cycle end of command
  output logic nack // target refused a byte
);

  typedef struct packed {
    logic sdaS1;
    logic sdaS2;
    logic sclOut;
    logic sdaOe;
    tof_pkg::tof_host_state_t st;
    logic [1:0] q;
    logic [4:0] tick;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic nak;
    tof_pkg::tof_op_t op;
    logic [7:0] regAddr;
    logic [7:0] data;
    logic [7:0] left;
    logic [1:0] sel;
    logic rs;
    logic busy;
    logic rdValid;
    logic [7:0] rdByte;
    logic done;
    logic nack;
  } tof_host_t;

  tof_host_t h;
  tof_host_t next_h;

  // ----------------------------------------
  // sequencer: four quarter phases per bit
  // ----------------------------------------
  always_comb begin
    next_h = h;
    next_h.sdaS1 = bus.sda;
    next_h.sdaS2 = h.sdaS1;
    next_h.rdValid = 1'b0;
    next_h.done = 1'b0;
    if (h.st == tof_pkg::HS_IDLE) begin
      if (cmdValid) begin
        next_h.op = cmdOp;
        next_h.sel = cmdSel;
        next_h.regAddr = cmdReg;
        next_h.data = cmdData;
        next_h.left = (cmdCount == 8'h00) ? 8'h01 : cmdCount;
        next_h.busy = 1'b1;
        next_h.nack = 1'b0;
        next_h.rs = 1'b0;
        next_h.q = 2'h0;
        next_h.tick = tof_pkg::QTR_LAST;
        next_h.st = tof_pkg::HS_START;
      end
    end else if (h.tick != 5'h00) begin
      next_h.tick = h.tick - 5'h01;
    end else begin
      next_h.tick = tof_pkg::QTR_LAST;
      next_h.q = h.q + 2'h1;
      case (h.st)
        tof_pkg::HS_START: begin
          // also a repeated start: sda released while scl is low
          case (h.q)
            2'h0: next_h.sdaOe = 1'b0;
            2'h1: next_h.sclOut = 1'b1;
            2'h2: next_h.sdaOe = 1'b1;
            default: begin
              next_h.sclOut = 1'b0;
              next_h.bitCnt = 4'h0;
              next_h.shift = tof_pkg::tof_addr_byte(h.sel,
                  h.rs || h.op == tof_pkg::OP_CURREAD); // [R05] [R16]
              next_h.st = tof_pkg::HS_ADDR;
            end
          endcase
        end
        tof_pkg::HS_STOP: begin
          case (h.q)
            2'h0: next_h.sdaOe = 1'b1;
            2'h1: next_h.sclOut = 1'b1;
            2'h2: next_h.sdaOe = 1'b0; // [R15] [R19]
            default: begin
              next_h.busy = 1'b0;
              next_h.done = 1'b1;
              next_h.st = tof_pkg::HS_IDLE;
            end
          endcase
        end
        default: begin
          case (h.q)
            2'h0: begin
              // data moves only with scl low [R06]
              if (h.bitCnt != tof_pkg::BIT_LAST) begin
                next_h.sdaOe = (h.st != tof_pkg::HS_RDATA) && !h.shift[7]; // [R02]
              end else begin
                next_h.sdaOe = (h.st == tof_pkg::HS_RDATA) && h.left != 8'h01; // [R12]
              end
            end
            2'h1: next_h.sclOut = 1'b1;
            2'h2: begin
              if (h.bitCnt != tof_pkg::BIT_LAST) begin
                next_h.shift = {h.shift[6:0], h.sdaS2};
              end else begin
                next_h.nak = h.sdaS2; // [R10]
              end
            end
            default: begin
              next_h.sclOut = 1'b0;
              next_h.bitCnt = h.bitCnt + 4'h1;
              if (h.bitCnt == tof_pkg::BIT_LAST) begin
                next_h.bitCnt = 4'h0;
                next_h.sdaOe = 1'b0;
                if (h.st != tof_pkg::HS_RDATA && h.nak) begin
                  next_h.nack = 1'b1;
                  next_h.st = tof_pkg::HS_STOP;
                end else begin
                  case (h.st)
                    tof_pkg::HS_ADDR: begin
                      if (h.shift[0] == tof_pkg::DIR_READ) begin
                        next_h.st = tof_pkg::HS_RDATA;
                      end else begin
                        next_h.shift = h.regAddr;
                        next_h.st = tof_pkg::HS_REG;
                      end
                    end
                    tof_pkg::HS_REG: begin
                      if (h.op == tof_pkg::OP_WRITE) begin
                        next_h.shift = h.data; // [R13]
                        next_h.st = tof_pkg::HS_WDATA;
                      end else begin
                        next_h.rs = 1'b1;
                        next_h.st = tof_pkg::HS_START;
                      end
                    end
                    tof_pkg::HS_RDATA: begin
                      next_h.rdValid = 1'b1;
                      next_h.rdByte = h.shift;
                      next_h.left = h.left - 8'h01;
                      if (h.left == 8'h01) begin
                        next_h.st = tof_pkg::HS_STOP;
                      end
                    end
                    default: next_h.st = tof_pkg::HS_STOP;
                  endcase
                end
              end
            end
          endcase
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      h <= '0;
      h.sclOut <= 1'b1;
    end else begin
      h <= next_h;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign bus.hostSclOut = h.sclOut; // [R01]
  assign bus.hostSclOe = 1'b1;
  assign bus.hostSdaOut = 1'b0;
  assign bus.hostSdaOe = h.sdaOe;
  assign busy = h.busy;
  assign rdValid = h.rdValid;
  assign rdByte = h.rdByte;
  assign done = h.done;
  assign nack = h.nack;

endmodule : tof_i2c_host

// [sim/tof_i2c_sva.sv]
// tof_i2c_sva: checks on bus A wires.
// assumes resolved bus A wires and select pin levels.
`timescale 1ns/1ps
module tof_i2c_sva (
  input wire logic mclk, // core clock
  input wire logic resetn, // reset, active low
  input wire logic scl, // clock wire
  input wire logic sda, // data wire
  input wire logic devSclOe, // device clock enable
  input wire logic devSdaOe, // device data enable
  input wire logic addrSelectUpperPin, // select bit 2
  input wire logic addrSelectLowerPin // select bit 1
);
  // ------------------------------
  // bus tracking
  // ------------------------------
  logic sclQ;
  logic sdaQ;
  logic [3:0] bitCnt;
  logic [1:0] byteIdx;
  logic [7:0] shiftV;
  logic addrAck;
  logic rdDir;
  wire startSeen = sclQ & scl & sdaQ & ~sda;
  wire stopSeen = sclQ & scl & ~sdaQ & sda;
  wire sclRise = ~sclQ & scl;
  wire ackSlot = sclRise & (bitCnt == 4'h8);
  // msb first
  wire addrOk = shiftV[7:1] == {5'h15, addrSelectUpperPin, addrSelectLowerPin};
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sclQ <= 1'b1;
      sdaQ <= 1'b1;
      bitCnt <= 4'h0;
      byteIdx <= 2'h0;
      shiftV <= 8'h00;
      addrAck <= 1'b0;
      rdDir <= 1'b0;
    end else begin
      sclQ <= scl;
      sdaQ <= sda;
      if (startSeen) begin
        bitCnt <= 4'h0;
        byteIdx <= 2'h0;
        addrAck <= 1'b0;
      end else if (ackSlot) begin
        bitCnt <= 4'h0;
        byteIdx <= (byteIdx == 2'h3) ? byteIdx : byteIdx + 2'h1;
        if (byteIdx == 2'h0) begin
          addrAck <= devSdaOe;
          rdDir <= shiftV[0];
        end
      end else if (sclRise) begin
        bitCnt <= bitCnt + 4'h1;
        shiftV <= {shiftV[6:0], sda};
      end
    end
  end
  // ------------------------------
  // assertions
  // ------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  AST_NO_SCL_DRIVE: assert property (
    !devSclOe) else $error("device drives scl");
  AST_ADDR_ACK: assert property (
    ackSlot && byteIdx == 2'h0 && addrOk |-> devSdaOe) else $error("address not acked");
  AST_ADDR_REFUSE: assert property (
    ackSlot && byteIdx == 2'h0 && !addrOk |-> !devSdaOe) else $error("foreign address acked");
  AST_ADDR_QUIET: assert property (
    sclRise && byteIdx == 2'h0 && bitCnt < 4'h8 |-> !devSdaOe) else $error("sda driven early");
  AST_WR_QUIET: assert property (
    sclRise && bitCnt < 4'h8 && addrAck && !rdDir |-> !devSdaOe) else $error("sda driven in write");
  AST_WR_ACK: assert property (
    ackSlot && byteIdx != 2'h0 && addrAck && !rdDir |-> devSdaOe) else $error("write byte not acked");
  AST_RD_RELEASE: assert property (
    ackSlot && byteIdx != 2'h0 && addrAck && rdDir |-> !devSdaOe) else $error("sda held at ack");
  AST_STOP_IDLE: assert property (
    stopSeen |-> ##1 !devSdaOe [*8]) else $error("sda driven after stop");
  AST_HIGH_STABLE: assert property (
    scl && $past(scl) |-> $stable(devSdaOe)) else $error("sda moved while scl high");
  COV_WRITE: cover property (@(posedge mclk) ackSlot && byteIdx == 2'h2 && addrAck && !rdDir);
  COV_READ: cover property (@(posedge mclk) ackSlot && byteIdx == 2'h3 && addrAck && rdDir);
  COV_REFUSE: cover property (@(posedge mclk) ackSlot && byteIdx == 2'h0 && !addrOk);
endmodule : tof_i2c_sva

// [sim/tof_sensor_i2c_slave_port_tb.sv]
// tof_sensor_i2c_slave_port_tb: host and device on bus A; device B driven by hand.
// assumes package, interface and both ends compiled first.
`timescale 1ns/1ps
module tof_sensor_i2c_slave_port_tb;
  typedef struct packed {
    logic [1:0] op;
    logic [1:0] sel;
    logic [7:0] regA;
    logic [7:0] data;
    logic [7:0] cnt;
    logic nck;
  } tof_row_t;
  logic mclk;
  logic linkClk;
  logic resetn = 1'b0;
  logic cmdValid = 1'b0;
  tof_pkg::tof_op_t cmdOp = tof_pkg::OP_WRITE;
  logic [1:0] cmdSel = 2'h0;
  logic [7:0] cmdReg = 8'h00;
  logic [7:0] cmdData = 8'h00;
  logic [7:0] cmdCount = 8'h00;
  logic busy;
  logic rdValid;
  logic [7:0] rdByte;
  logic done;
  logic nack;
  logic selUpper = 1'b1;
  logic selLower = 1'b0;
  logic wrStrobe;
  logic [7:0] wrAddr;
  logic [7:0] wrData;
  logic [7:0] rdAddr;
  logic [7:0] rdData;
  logic wrStrobeB;
  logic [7:0] wrAddrB;
  logic [7:0] wrDataB;
  logic [7:0] wrCount = 8'h00;
  logic [7:0] wrCountB = 8'h00;
  logic [7:0] core [256];
  logic [7:0] expMem [256];
  int failCount = 0;
  int checksDone = 0;
  // op: 0 write, 1 current read, 2 random read; pins select 2
  tof_row_t rows [8] = '{
    '{2'h0, 2'h2, 8'h10, 8'h3C, 8'h00, 1'b0},
    '{2'h0, 2'h2, 8'hFF, 8'hA5, 8'h00, 1'b0},
    '{2'h2, 2'h2, 8'h10, 8'h00, 8'h01, 1'b0},
    '{2'h1, 2'h2, 8'h10, 8'h00, 8'h02, 1'b0},
    '{2'h2, 2'h2, 8'hFE, 8'h00, 8'h03, 1'b0},
    '{2'h0, 2'h1, 8'h40, 8'h77, 8'h00, 1'b1},
    '{2'h1, 2'h2, 8'h00, 8'h00, 8'h00, 1'b0},
    '{2'h2, 2'h3, 8'h05, 8'h00, 8'h01, 1'b1}
  };
  tof_i2c_if busA ();
  tof_i2c_if busB ();
  tof_i2c_host i_tof_i2c_host (.mclk(mclk), .resetn(resetn), .bus(busA.host), .cmdValid(cmdValid),
    .cmdOp(cmdOp), .cmdSel(cmdSel), .cmdReg(cmdReg), .cmdData(cmdData), .cmdCount(cmdCount),
    .busy(busy), .rdValid(rdValid), .rdByte(rdByte), .done(done), .nack(nack));
  tof_i2c_dev i_tof_i2c_dev (.mclk(mclk), .resetn(resetn), .linkClk(linkClk), .bus(busA.dev),
    .addrSelectUpperPin(selUpper), .addrSelectLowerPin(selLower), .wrStrobe(wrStrobe),
    .wrAddr(wrAddr), .wrData(wrData), .rdStrobe(), .rdAddr(rdAddr), .rdData(rdData));
  tof_i2c_dev i_tof_i2c_dev_b (.mclk(mclk), .resetn(resetn), .linkClk(linkClk), .bus(busB.dev),
    .addrSelectUpperPin(1'b0), .addrSelectLowerPin(1'b0), .wrStrobe(wrStrobeB),
    .wrAddr(wrAddrB), .wrData(wrDataB), .rdStrobe(), .rdAddr(), .rdData(8'h00));
  tof_i2c_sva i_tof_i2c_sva (.mclk(mclk), .resetn(resetn), .scl(busA.scl),
    .sda(busA.sda), .devSclOe(busA.devSclOe), .devSdaOe(busA.devSdaOe),
    .addrSelectUpperPin(selUpper), .addrSelectLowerPin(selLower));
  // combinational core: fetch ready next cycle
  assign rdData = core[rdAddr];
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    linkClk = 1'b0;
    #7;
    forever #24 linkClk = ~linkClk;
  end
  always @(posedge mclk) begin
    if (wrStrobe === 1'b1) begin
      core[wrAddr] <= wrData;
      wrCount <= wrCount + 8'h01;
    end
    if (wrStrobeB === 1'b1) wrCountB <= wrCountB + 8'h01;
  end
  // ------------------------------
  // tasks
  // ------------------------------
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checksDone++;
    if (seen !== exp) begin
      $display("BAD %s expected %h seen %h", nm, exp, seen);
      failCount++;
    end
  endtask : chk
  task automatic results();
    $display("checks %0d mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  task automatic runCmd(input tof_row_t r);
    int n;
    int t;
    logic [7:0] w0;
    n = 0;
    w0 = wrCount;
    cmdValid = 1'b1;
    cmdOp = tof_pkg::tof_op_t'(r.op);
    cmdSel = r.sel;
    cmdReg = r.regA;
    cmdData = r.data;
    cmdCount = r.cnt;
    tick(1);
    cmdValid = 1'b0;
    for (t = 0; t < 20000; t++) begin
      tick(1);
      if (rdValid === 1'b1) begin
        chk("rdByte", rdByte, expMem[r.regA + 8'(n)]);
        n++;
      end
      if (done === 1'b1) break;
    end
    if (t == 20000) begin
      failCount++;
      results();
    end
    chk("nack", 8'(nack), 8'(r.nck));
    if (r.op == 2'h0) begin
      chk("writes", wrCount - w0, 8'(!r.nck));
      if (!r.nck) begin
        chk("wrAddr", wrAddr, r.regA);
        chk("wrData", wrData, r.data);
        expMem[r.regA] = r.data;
      end
    end else begin
      chk("bytes", 8'(n), r.nck ? 8'h00 : (r.cnt == 8'h00 ? 8'h01 : r.cnt));
    end
  endtask : runCmd
  task automatic qtr(input logic c, input logic d);
    busB.hostSclOut = c;
    busB.hostSdaOe = ~d;
    tick(13);
  endtask : qtr
  task automatic sendBits(input logic [7:0] v, input int nb);
    for (int i = 7; i > 7 - nb; i--) begin
      qtr(1'b0, v[i]);
      qtr(1'b1, v[i]);
      qtr(1'b0, v[i]);
    end
  endtask : sendBits
  task automatic byteB(input logic [7:0] v);
    sendBits(v, 8);
    qtr(1'b0, 1'b1);
    qtr(1'b1, 1'b1);
    chk("ackB", 8'(busB.sda), 8'h00);
    qtr(1'b0, 1'b1);
  endtask : byteB
  // full=0 stops mid data byte
  task automatic frameB(input logic [7:0] regA, input logic [7:0] v, input logic full);
    qtr(1'b1, 1'b1);
    qtr(1'b1, 1'b0);
    qtr(1'b0, 1'b0);
    byteB(8'hA8);
    byteB(regA);
    if (full) byteB(v);
    else sendBits(v, 4);
    qtr(1'b0, 1'b0);
    qtr(1'b1, 1'b0);
    qtr(1'b1, 1'b1);
  endtask : frameB
  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    busB.hostSclOe = 1'b1;
    busB.hostSdaOut = 1'b0;
    busB.hostSclOut = 1'b1;
    busB.hostSdaOe = 1'b0;
    for (int i = 0; i < 256; i++) begin
      core[i] = 8'(i) ^ 8'h5A;
      expMem[i] = 8'(i) ^ 8'h5A;
    end
    tick(16);
    resetn = 1'b1;
    for (int i = 0; i < 8; i++) runCmd(rows[i]);
    for (int i = 0; i < 4; i++) begin
      {selUpper, selLower} = 2'(i);
      tick(4);
      runCmd('{2'h0, 2'(i), 8'h20 + 8'(i), 8'h90 + 8'(i), 8'h00, 1'b0});
    end
    cmdOp = tof_pkg::OP_RNDREAD;
    cmdValid = 1'b1;
    tick(1);
    cmdValid = 1'b0;
    tick(300);
    resetn = 1'b0;
    tick(2);
    chk("rstSda", 8'(busA.devSdaOe), 8'h00);
    chk("rstScl", 8'(busA.scl), 8'h01);
    tick(14);
    resetn = 1'b1;
    runCmd('{2'h1, 2'h3, 8'h00, 8'h00, 8'h01, 1'b0});
    frameB(8'h20, 8'hC3, 1'b0);
    tick(8);
    chk("abortWrites", wrCountB, 8'h00);
    frameB(8'h21, 8'hC1, 1'b1);
    tick(8);
    chk("writesB", wrCountB, 8'h01);
    chk("wrAddrB", wrAddrB, 8'h21);
    chk("wrDataB", wrDataB, 8'hC1);
    results();
  end
endmodule : tof_sensor_i2c_slave_port_tb
